/* File: hdl/fpm_fault_manager.sv */
`timescale 1ns/1ps
`include "fpm_defines.svh"

// ==========================================================
// Overview
// ==========================================================
// The block decides when the gate drive may switch and how the controller
// reacts once a fault has been seen. It does not measure anything itself:
// every fault arrives as an active-high level from a comparator or a timer
// elsewhere in the controller, and the block only times and sorts them.
//
// Start-up always passes through the terminal check. The drive is enabled
// only once that check reports done with no fault present, so a board
// fault found at power-up never produces a single pulse.
//
// While switching, the level faults must persist for the short filter time
// and for two switching periods, whichever ends later. A glitch that clears
// before both have run resets its counter and leaves the drive untouched.
//
// Faults fall into two groups. Latching faults park the sequencer until the
// mains goes away, while the start-up source holds the supply between two
// levels. Auto-restart faults start a timed low-power delay, then discharge
// the supply and retry from the terminal check, forever if need be.
//
// A limitation worth knowing: the restart delays are plain counters of the
// system clock, so their length scales with the clock and with the
// parameters, not with any analog timing of the supply.
module fpm_fault_manager #(
	parameter int unsigned SHORT_FILT_CYC  = `FPM_SHORT_FILT_CYC,
	parameter int unsigned BROWNOUT_CYC    = `FPM_BROWNOUT_CYC,
	parameter int unsigned RESTART_LONG    = `FPM_RESTART_LONG_CYC,
	parameter int unsigned RESTART_SHORT   = `FPM_RESTART_SHORT_CYC,
	parameter int unsigned CNT_W           = 28
) (
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst_n,
	// Power stage and supply conditions, all active high.
	input  wire logic sup_ov,
	input  wire logic sup_uv,
	input  wire logic overtemp,
	input  wire logic overtemp_cool,
	input  wire logic shutdown_input_low,
	input  wire logic shutdown_input_wake,
	input  wire logic out_ov,
	input  wire logic brownout,
	input  wire logic line_uv,
	input  wire logic xcap_discharge,
	input  wire logic overload_expired,
	input  wire logic pwm_period_tick,
	input  wire logic low_power_req,
	// Start-up terminal check results.
	input  wire logic check_done,
	input  wire logic term_latch_fault,
	input  wire logic term_no_start,
	input  wire logic diag_fault,
	// Supply levels and mains presence.
	input  wire logic ac_present,
	input  wire logic supply_discharge_level,
	input  wire logic latched_supply_upper_level,
	input  wire logic latched_supply_lower_level,
	// Outputs.
	output logic      pwm_enable,
	output logic      check_start,
	output logic      startup_source_on,
	output logic      discharge_on,
	output logic      shutdown_pullup_on,
	output logic      low_power,
	output logic      latched,
	output fpm_pkg::fpm_state_t state
);
	import fpm_pkg::*;

	// ==========================================================
	// Persistence filters
	// ==========================================================
	logic [`FPM_NFILT-1:0] fin;
	logic [`FPM_NFILT-1:0] fhit;
	logic                  arm_f;
	fpm_state_t            state_r;
	// The filter inputs are packed in the order of the fault indices, so the
	// latch mask can pick the latching ones with a single AND.
	assign fin = {out_ov, shutdown_input_low, overtemp, sup_uv, sup_ov};
	// Filters run only while switching; pre-PWM faults are handled by the check.
	assign arm_f = (state_r == FPM_RUN);

	// One filter per level fault. Each keeps a time counter and a period
	// counter; both saturate, so a fault that stays forever cannot wrap the
	// counters and release the hit by accident.
	genvar gi;
	generate
		for (gi = 0; gi < `FPM_NFILT; gi++) begin : g_filt
			logic [CNT_W-1:0] tcnt_r, tcnt_nxt;
			logic [1:0]       pcnt_r, pcnt_nxt;
			logic             hit_r, hit_nxt;
			// Both the time and period counts must expire; the larger one wins.
			always_comb begin
				tcnt_nxt = tcnt_r;
				pcnt_nxt = pcnt_r;
				hit_nxt  = 1'b0;
				if (!fin[gi] || !arm_f) begin
					tcnt_nxt = '0;
					pcnt_nxt = '0;
				end else begin
					if (tcnt_r < CNT_W'(SHORT_FILT_CYC)) tcnt_nxt = tcnt_r + 1'b1;
					if (pwm_period_tick && pcnt_r < 2'(`FPM_PWM_PERIODS))
						pcnt_nxt = pcnt_r + 2'h1;
					hit_nxt = (tcnt_r >= CNT_W'(SHORT_FILT_CYC)) &&
						(pcnt_r >= 2'(`FPM_PWM_PERIODS));
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					tcnt_r <= '0;
					pcnt_r <= 2'h0;
					hit_r  <= 1'b0;
				end else begin
					tcnt_r <= tcnt_nxt;
					pcnt_r <= pcnt_nxt;
					hit_r  <= hit_nxt;
				end
			end
			assign fhit[gi] = hit_r;
		end
	endgenerate

	// ==========================================================
	// Brownout filter and fault classification
	// ==========================================================
	// Brownout uses its own long persistence and ignores the switching
	// periods; a mains dip is slow compared with any switching period.
	logic [CNT_W-1:0] bcnt_r, bcnt_nxt;
	logic             bhit;
	always_comb begin
		bcnt_nxt = '0;
		if (brownout && arm_f && bcnt_r < CNT_W'(BROWNOUT_CYC))
			bcnt_nxt = bcnt_r + 1'b1;
		else if (brownout && arm_f)
			bcnt_nxt = bcnt_r;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) bcnt_r <= '0;
		else        bcnt_r <= bcnt_nxt;
	end
	assign bhit = (bcnt_r >= CNT_W'(BROWNOUT_CYC));

	logic latch_hit, auto_hit, short_hit;
	// Supply OV, overtemp, shutdown low and output OV latch.
	assign latch_hit = |(fhit & `FPM_NFILT'(`FPM_LATCH_MASK));
	// Supply UV, brownout, overload, line UV and X-cap events hiccup.
	assign short_hit = arm_f && (line_uv || xcap_discharge);
	assign auto_hit  = (fhit[`FPM_F_SUP_UV]) || bhit ||
		(arm_f && overload_expired) || short_hit;

	// ==========================================================
	// Sequencer
	// ==========================================================
	// The sequencer owns the restart delay counter and the hysteretic source
	// control. The overtemperature flag remembers why the latch was taken so
	// that a mains cycle alone cannot restart a chip that is still hot.
	fpm_state_t       state_nxt;
	logic [CNT_W-1:0] dly_r, dly_nxt;
	logic             src_r, src_nxt;
	logic             otl_r, otl_nxt;
	logic             wake_prev_r;
	logic             wake_rise;
	assign wake_rise = shutdown_input_wake && !wake_prev_r;

	always_comb begin
		state_nxt = state_r;
		dly_nxt   = dly_r;
		src_nxt   = src_r;
		otl_nxt   = otl_r;
		case (state_r)
			FPM_OFF: begin
				// Overtemp latch waits for the cool-down flag before restarting.
				if (ac_present && (!otl_r || overtemp_cool)) begin
					otl_nxt   = 1'b0;
					state_nxt = FPM_CHECK;
				end
			end
			FPM_CHECK: begin
				if (!ac_present) state_nxt = FPM_OFF;
				else if (term_latch_fault || diag_fault || shutdown_input_low ||
					sup_ov || overtemp || out_ov)
					state_nxt = FPM_LATCHED;
				else if (term_no_start) state_nxt = FPM_OFF;
				else if (check_done && (sup_uv || brownout)) begin
					// A supply fault at start-up hiccups again without a pulse.
					dly_nxt   = CNT_W'(RESTART_LONG);
					state_nxt = FPM_DELAY;
				end else if (check_done)
					state_nxt = FPM_RUN;
			end
			FPM_RUN: begin
				if (latch_hit) begin
					otl_nxt   = fhit[`FPM_F_OVERTEMP];
					state_nxt = FPM_LATCHED;
				end else if (auto_hit) begin
					dly_nxt   = short_hit ? CNT_W'(RESTART_SHORT) : CNT_W'(RESTART_LONG);
					state_nxt = FPM_DELAY;
				end else if (low_power_req) state_nxt = FPM_SLEEP;
			end
			FPM_SLEEP: begin
				if (wake_rise || !low_power_req) state_nxt = FPM_RUN;
			end
			FPM_DELAY: begin
				if (dly_r == '0) state_nxt = FPM_DISCH;
				else dly_nxt = dly_r - 1'b1;
			end
			FPM_DISCH: begin
				if (supply_discharge_level) state_nxt = FPM_OFF;
			end
			FPM_LATCHED: begin
				// Hysteretic bias keeps the latch alive while mains stays.
				if (latched_supply_lower_level) src_nxt = 1'b1;
				else if (latched_supply_upper_level) src_nxt = 1'b0;
				if (!ac_present) begin
					src_nxt   = 1'b0;
					state_nxt = FPM_OFF;
				end
			end
			default: state_nxt = FPM_OFF;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= FPM_OFF;
			dly_r       <= '0;
			src_r       <= 1'b0;
			otl_r       <= 1'b0;
			wake_prev_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			dly_r       <= dly_nxt;
			src_r       <= src_nxt;
			otl_r       <= otl_nxt;
			wake_prev_r <= shutdown_input_wake;
		end
	end

	// ==========================================================
	// Registered outputs
	// ==========================================================
	// Every output is computed from the next state and registered, so the
	// pins change on the same edge as the state and never glitch. The cost
	// is that the outputs follow the inputs one cycle later than a purely
	// combinational decode would.
	// The pull-up is the inverse of low power: it is off in every low-power
	// state, and in FPM_SLEEP the shutdown pin then serves as a wake input.
	logic lp_nxt;
	assign lp_nxt = (state_nxt == FPM_DELAY) || (state_nxt == FPM_LATCHED) ||
		(state_nxt == FPM_SLEEP);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_enable         <= 1'b0;
			check_start        <= 1'b0;
			startup_source_on  <= 1'b0;
			discharge_on       <= 1'b0;
			shutdown_pullup_on <= 1'b0;
			low_power          <= 1'b0;
			latched            <= 1'b0;
			state              <= FPM_OFF;
		end else begin
			pwm_enable         <= (state_nxt == FPM_RUN);
			check_start        <= (state_nxt == FPM_CHECK);
			startup_source_on  <= (state_nxt == FPM_LATCHED) ? src_nxt :
				(state_nxt == FPM_OFF);
			discharge_on       <= (state_nxt == FPM_DISCH);
			shutdown_pullup_on <= !lp_nxt;
			low_power          <= lp_nxt;
			latched            <= (state_nxt == FPM_LATCHED);
			state              <= state_nxt;
		end
	end
endmodule : fpm_fault_manager

/* File: hdl/fpm_defines.svh */
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
// Short persistence time in ns and its cycle count at 100 MHz (10 ns period).
`define FPM_SHORT_FILT_NS      125000
`define FPM_CLK_NS             10
`define FPM_SHORT_FILT_CYC     (`FPM_SHORT_FILT_NS / `FPM_CLK_NS)
// Brownout persistence time in ms and its cycle count.
`define FPM_BROWNOUT_MS        40
`define FPM_BROWNOUT_CYC       (`FPM_BROWNOUT_MS * 1000000 / `FPM_CLK_NS)
// Number of PWM periods that also bound the short filter.
`define FPM_PWM_PERIODS        2
// Restart delays in ms; arbitrary defaults, no figure given.
`define FPM_RESTART_LONG_MS    1500
`define FPM_RESTART_SHORT_MS   100
`define FPM_RESTART_LONG_CYC   (`FPM_RESTART_LONG_MS * 1000000 / `FPM_CLK_NS)
`define FPM_RESTART_SHORT_CYC  (`FPM_RESTART_SHORT_MS * 1000000 / `FPM_CLK_NS)
// Filtered fault indices.
`define FPM_F_SUP_OV           0
`define FPM_F_SUP_UV           1
`define FPM_F_OVERTEMP         2
`define FPM_F_SHUTDOWN         3
`define FPM_F_OUT_OV           4
`define FPM_NFILT              5
// Mask of latching filtered faults (supply OV, overtemp, shutdown, output OV).
`define FPM_LATCH_MASK         5'h1D
`endif

/* File: hdl/fpm_pkg.sv */
package fpm_pkg;
	// Sequencer states, Gray coded along off, check, run, delay, discharge path.
	typedef enum logic [2:0] {
		FPM_OFF     = 3'b000,
		FPM_CHECK   = 3'b001,
		FPM_RUN     = 3'b011,
		FPM_DELAY   = 3'b010,
		FPM_DISCH   = 3'b110,
		FPM_LATCHED = 3'b111,
		FPM_SLEEP   = 3'b101
	} fpm_state_t;
endpackage : fpm_pkg

/* File: testbench/fpm_fault_manager_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// Checker on the fault manager ports.
module fpm_fault_manager_asserts
	import fpm_pkg::*;
(
	// Clock, reset and inputs.
	input logic mclk, rst_n, sup_ov, line_uv, xcap_discharge, term_latch_fault,
	input logic ac_present, latched_supply_upper_level, latched_supply_lower_level,
	// Outputs.
	input logic pwm_enable, check_start, startup_source_on, discharge_on,
	input logic shutdown_pullup_on, low_power, latched,
	input fpm_pkg::fpm_state_t state
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_pwm; pwm_enable |-> state == FPM_RUN; endproperty
	a_pwm: assert property (p_pwm) else $error("pwm outside run");
	property p_chk; state == FPM_CHECK |-> check_start && !pwm_enable; endproperty
	a_chk: assert property (p_chk) else $error("check phase wrong");
	// A supply OV rise may not stop the drive within six cycles.
	property p_flt; state == FPM_RUN && pwm_enable && $rose(sup_ov) && !line_uv
		&& !xcap_discharge |-> pwm_enable[*6]; endproperty
	a_flt: assert property (p_flt) else $error("fault not filtered");
	property p_lat; latched |-> !pwm_enable; endproperty
	a_lat: assert property (p_lat) else $error("pwm while latched");
	property p_lo; state == FPM_LATCHED && latched_supply_lower_level |=> startup_source_on;
	endproperty
	a_lo: assert property (p_lo) else $error("source off at low level");
	property p_hi; state == FPM_LATCHED && latched_supply_upper_level
		&& !latched_supply_lower_level && ac_present |=> !startup_source_on; endproperty
	a_hi: assert property (p_hi) else $error("source on at high level");
	property p_ac; state == FPM_LATCHED && !ac_present |-> ##[1:2] state == FPM_OFF;
	endproperty
	a_ac: assert property (p_ac) else $error("latch kept without mains");
	property p_dly; $rose(state == FPM_DELAY) |-> (state == FPM_DELAY)[*8]; endproperty
	a_dly: assert property (p_dly) else $error("restart delay short");
	property p_dis; state == FPM_DISCH |-> discharge_on && !pwm_enable; endproperty
	a_dis: assert property (p_dis) else $error("no discharge");
	property p_pu; state == FPM_RUN |-> shutdown_pullup_on; endproperty
	a_pu: assert property (p_pu) else $error("pull-up off in run");
	property p_slp; state == FPM_SLEEP |-> low_power && !shutdown_pullup_on; endproperty
	a_slp: assert property (p_slp) else $error("sleep outputs wrong");
	property p_tf; state == FPM_CHECK && term_latch_fault |=> state == FPM_LATCHED;
	endproperty
	a_tf: assert property (p_tf) else $error("terminal fault not latched");
	c_lat: cover property (state == FPM_LATCHED && latched_supply_lower_level);
	c_slp: cover property (state == FPM_SLEEP);
	c_dly: cover property ($rose(state == FPM_DELAY));
endmodule : fpm_fault_manager_asserts

bind fpm_fault_manager fpm_fault_manager_asserts u_chk (.mclk, .rst_n, .sup_ov, .line_uv,
	.xcap_discharge, .term_latch_fault, .ac_present, .latched_supply_upper_level,
	.latched_supply_lower_level, .pwm_enable, .check_start, .startup_source_on,
	.discharge_on, .shutdown_pullup_on, .low_power, .latched, .state);

/* File: testbench/fpm_partner.sv */
`timescale 1ns/1ps
// ==========================================
// Bias supply, power stage and check model.
module fpm_partner #(
	parameter int CHK_DLY = 3
) (
	input  logic mclk, rst_n, startup_source_on, discharge_on, check_start,
	output logic supply_discharge_level, latched_supply_upper_level,
	output logic latched_supply_lower_level, check_done, pwm_period_tick
);
	int v, c, t;
	// Source charges, discharge drains fast, the bias load drains slowly.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			v <= 0;
			c <= 0;
			t <= 0;
		end else begin
			if (discharge_on) v <= (v > 2) ? v - 2 : 0;
			else if (startup_source_on) v <= (v < 60) ? v + 1 : 60;
			else v <= (v > 0) ? v - 1 : 0;
			c <= check_start ? c + 1 : 0;
			t <= (t == 2) ? 0 : t + 1;
		end
	end
	// Comparator levels; the check answer is slow so CHECK lasts several cycles.
	assign supply_discharge_level = v <= 4;
	assign latched_supply_upper_level = v >= 40;
	assign latched_supply_lower_level = v <= 20;
	assign check_done = c >= CHK_DLY;
	assign pwm_period_tick = (t == 0);
endmodule : fpm_partner

/* File: testbench/fpm_fault_manager_tb.sv */
`timescale 1ns/1ps
// ==========================================
// Fault manager bench.
module fpm_fault_manager_tb;
	import fpm_pkg::*;
	localparam int FILT = 8, BRN = 20, LONG = 30, SHORT = 10;
	// Inputs start quiet with mains absent.
	logic mclk = 0, rst_n = 0, ac_present = 0, overtemp_cool = 1, sup_ov = 0, sup_uv = 0;
	logic overtemp = 0, shutdown_input_low = 0, out_ov = 0, brownout = 0, line_uv = 0;
	logic xcap_discharge = 0, overload_expired = 0, low_power_req = 0;
	logic shutdown_input_wake = 0, term_latch_fault = 0, term_no_start = 0, diag_fault = 0;
	logic pwm_period_tick, check_done, supply_discharge_level, latched_supply_upper_level;
	logic latched_supply_lower_level, pwm_enable, check_start, startup_source_on;
	logic discharge_on, shutdown_pullup_on, low_power, latched;
	fpm_state_t state;
	int errors = 0, checks = 0;
	fpm_fault_manager #(.SHORT_FILT_CYC(FILT), .BROWNOUT_CYC(BRN), .RESTART_LONG(LONG),
		.RESTART_SHORT(SHORT)) DUT (.*);
	fpm_partner #(.CHK_DLY(3)) PM (.*);
	initial forever #5 mclk = ~mclk;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// State is read just after an edge, so it is the value held before that edge.
	task automatic wt(input fpm_state_t st);
		for (int i = 0; i < 300 && state !== st; i++) @(posedge mclk);
		if (state !== st) begin
			chk(state, st);
			end_sim();
		end
	endtask : wt
	task automatic dly(input logic [7:0] n);
		logic [7:0] c = 0;
		wt(FPM_DELAY);
		while (state === FPM_DELAY && c < 8'hFF) begin
			c++;
			@(posedge mclk);
		end
		chk(c, n);
	endtask : dly
	task automatic flt(input int k, input logic v);
		case (k)
			0: sup_uv <= v;
			1: brownout <= v;
			2: line_uv <= v;
			3: xcap_discharge <= v;
			4: overload_expired <= v;
			5: sup_ov <= v;
			6: overtemp <= v;
			7: shutdown_input_low <= v;
			8: out_ov <= v;
			9: term_latch_fault <= v;
			10: term_no_start <= v;
			11: diag_fault <= v;
			default: ;
		endcase
	endtask : flt
	// Mains cycle from latched; fault k is present at the next start-up.
	task automatic rec(input int k);
		ac_present <= 1'b0;
		wt(FPM_OFF);
		flt(k, 1'b1);
		ac_present <= 1'b1;
		if (!overtemp_cool) begin
			repeat (20) @(posedge mclk);
			chk(state, FPM_OFF);
			overtemp_cool <= 1'b1;
		end
		if (k >= 0) begin
			for (int i = 0; i < 30; i++) begin
				@(posedge mclk);
				chk(pwm_enable, 1'b0);
			end
			chk(latched, k != 10);
			flt(k, 1'b0);
		end
		if (k < 0 || k == 10) wt(FPM_RUN);
	endtask : rec
	task automatic t_filter;
		for (int k = 0; k < 2; k++) begin
			flt(k, 1'b1);
			repeat (k ? BRN - 5 : FILT - 3) @(posedge mclk);
			flt(k, 1'b0);
			repeat (20) @(posedge mclk);
			chk(state, FPM_RUN);
		end
		$display("test filter done");
	endtask : t_filter
	// Held undervoltage hiccups twice, then each auto-restart source once.
	task automatic t_auto;
		flt(0, 1'b1);
		dly(LONG + 1);
		dly(LONG + 1);
		flt(0, 1'b0);
		wt(FPM_RUN);
		for (int k = 1; k < 5; k++) begin
			flt(k, 1'b1);
			dly((k == 2 || k == 3) ? SHORT + 1 : LONG + 1);
			flt(k, 1'b0);
			wt(FPM_RUN);
		end
		$display("test auto done");
	endtask : t_auto
	task automatic t_sleep;
		chk(shutdown_pullup_on, 1'b1);
		low_power_req <= 1'b1;
		wt(FPM_SLEEP);
		chk(shutdown_pullup_on, 1'b0);
		chk(low_power, 1'b1);
		shutdown_input_wake <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(pwm_enable, 1'b1);
		low_power_req <= 1'b0;
		shutdown_input_wake <= 1'b0;
		wt(FPM_RUN);
		$display("test sleep done");
	endtask : t_sleep
	// Supply overvoltage comes with undervoltage to test latch precedence.
	task automatic t_latch;
		for (int k = 5; k < 9; k++) begin
			flt(k, 1'b1);
			if (k == 5) flt(0, 1'b1);
			wt(FPM_LATCHED);
			chk(latched, 1'b1);
			flt(k, 1'b0);
			flt(0, 1'b0);
			overtemp_cool <= (k != 6);
			repeat (80) @(posedge mclk);
			chk(state, FPM_LATCHED);
			if (k < 7) rec(k == 5 ? 9 : 11);
			rec(k == 5 ? 10 : -1);
		end
		$display("test latch done");
	endtask : t_latch
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		ac_present <= 1'b1;
		wt(FPM_RUN);
		t_filter();
		t_auto();
		t_sleep();
		t_latch();
		end_sim();
	end
endmodule : fpm_fault_manager_tb
